// >>> sic_defs.svh
// register offsets, field positions, reset values and timing bases
// assumes: included by the design files by bare name
`ifndef SIC_DEFS_SVH
`define SIC_DEFS_SVH

// ============================================================
// register offsets (byte addresses)
`define SIC_OFF_INIT_CTRL   8'h00
`define SIC_OFF_PD_CTRL     8'h04
`define SIC_OFF_DPD_CTRL    8'h08
`define SIC_OFF_GEOM0       8'h0C
`define SIC_OFF_GEOM1       8'h10
`define SIC_OFF_INIT_TIMING 8'h14
`define SIC_OFF_IRQ_STATUS  8'h18
`define SIC_OFF_IRQ_ENABLE  8'h1C
`define SIC_OFF_IRQ_CLEAR   8'h20

// ============================================================
// field positions
`define SIC_LAUNCH_BIT      0
`define SIC_BUSY_BIT        16
`define SIC_PD_BIT          0
`define SIC_WIDTH_LSB       8
`define SIC_SIZE_LSB        0
`define SIC_PRECH_LSB       8
`define SIC_RCNT_LSB        4
`define SIC_RINT_LSB        0

// ============================================================
// encodings, reset values and timing bases
`define SIC_WIDTH_8         2'h0
`define SIC_WIDTH_16        2'h1
`define SIC_GEOM_RESET      5'h00
`define SIC_TIMING_RESET    11'h000
`define SIC_PRECH_BASE      4'h3
`define SIC_RINT_BASE       5'h03
`define SIC_RESP_OKAY       2'h0
`define SIC_RESP_SLVERR     2'h2
`define SIC_IRQ_INIT_DONE   0
`define SIC_IRQ_PD_ENTER    1
`define SIC_IRQ_DPD_ENTER   2

`endif

// >>> sic_pkg.sv
// shared types of the sdram init and power configuration block
// assumes: compiled before the interface and modules
package sic_pkg;
	typedef logic [1:0] sic_width_type;
	typedef logic [2:0] sic_size_type;
	typedef enum logic [1:0] {
		SIC_IDLE,
		SIC_PRECH,
		SIC_REFR
	} sic_init_state_type;
	typedef enum logic {
		SIC_CH_IDLE,
		SIC_CH_SPLIT
	} sic_chan_state_type;
endpackage

// >>> sic_chan_if.sv
// channel configuration and access request bundle
// assumes: one instance per sdram channel, single clock
`timescale 1ns/1ps
`default_nettype none
interface sic_chan_if;
	import sic_pkg::*;
	sic_width_type cfg_width;
	sic_size_type  cfg_size;
	logic          req_valid;
	logic          req_ready;
	logic [31:0]   req_addr;
	logic          req_word;
	logic          beat_valid;
	logic [31:0]   beat_addr;
	logic          beat_last;
	modport ctl (output cfg_width, cfg_size, req_valid, req_addr, req_word,
		input req_ready, beat_valid, beat_addr, beat_last);
	modport chan (input cfg_width, cfg_size, req_valid, req_addr, req_word,
		output req_ready, beat_valid, beat_addr, beat_last);
endinterface // sic_chan_if
`default_nettype wire

// >>> sic_chan_split.sv
// per-channel access splitter with size aliasing
// assumes: same clock as the register block, one beat per cycle
`timescale 1ns/1ps
`default_nettype none
`include "sic_defs.svh"
module sic_chan_split #(
	// log2 of the decoded byte size for each size code
	parameter logic [7:0][4:0] SIZE_LOG2 = {5'h1B, 5'h1A, 5'h19, 5'h18,
		5'h17, 5'h16, 5'h15, 5'h14}
) (
	input  wire logic sys_clk,
	input  wire logic rstn,
	sic_chan_if.chan  ch
);
	import sic_pkg::*;

	sic_chan_state_type state_q;
	logic [31:0]        mask;
	logic [1:0]         beats_left_q;
	logic [31:0]        addr_q;
	logic [2:0]         step;

	// alias mask from the size table
	assign mask = (32'h1 << SIZE_LOG2[ch.cfg_size]) - 32'h1;
	assign step = (ch.cfg_width == `SIC_WIDTH_16) ? 3'h2 : 3'h1;
	assign ch.req_ready = (state_q == SIC_CH_IDLE);

	// ============================================================
	// beat sequencing
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_q <= SIC_CH_IDLE;
			beats_left_q <= 2'h0;
			addr_q <= 32'h0;
			ch.beat_valid <= 1'b0;
			ch.beat_addr <= 32'h0;
			ch.beat_last <= 1'b0;
		end else begin
			ch.beat_valid <= 1'b0;
			ch.beat_last <= 1'b0;
			unique case (state_q)
				SIC_CH_IDLE: if (ch.req_valid) begin
					ch.beat_valid <= 1'b1;
					if (ch.req_word && ch.cfg_width == `SIC_WIDTH_16) begin
						// low half (A1 = 0) first, high half next
						ch.beat_addr <= ch.req_addr & mask & 32'hFFFFFFFC;
						addr_q <= (ch.req_addr & mask & 32'hFFFFFFFC) + 32'h2;
						beats_left_q <= 2'h0;
						state_q <= SIC_CH_SPLIT;
					end else if (ch.req_word && ch.cfg_width == `SIC_WIDTH_8) begin
						ch.beat_addr <= ch.req_addr & mask & 32'hFFFFFFFC;
						addr_q <= (ch.req_addr & mask & 32'hFFFFFFFC) + 32'h1;
						beats_left_q <= 2'h2;
						state_q <= SIC_CH_SPLIT;
					end else begin
						ch.beat_addr <= ch.req_addr & mask;
						ch.beat_last <= 1'b1;
					end
				end
				SIC_CH_SPLIT: begin
					ch.beat_valid <= 1'b1;
					ch.beat_addr <= addr_q;
					addr_q <= addr_q + {29'h0, step};
					beats_left_q <= beats_left_q - 2'h1;
					if (beats_left_q == 2'h0) begin
						ch.beat_last <= 1'b1;
						state_q <= SIC_CH_IDLE;
					end
				end
			endcase
		end
	end

	// ============================================================
	// checks
	split_order_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ch.beat_valid && !ch.beat_last && ch.cfg_width == `SIC_WIDTH_16
		|-> !ch.beat_addr[1] ##1 (ch.beat_valid && ch.beat_addr[1]
		&& ch.beat_last))
		else $error("16-bit split order wrong");
	alias_mask_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ch.beat_valid && $stable(ch.cfg_size) |-> (ch.beat_addr & ~mask) == 32'h0)
		else $error("beat address outside channel size");
	split_cov: cover property (@(posedge sys_clk) disable iff (!rstn)
		ch.beat_valid && !ch.beat_last ##1 ch.beat_last);
endmodule // sic_chan_split
`default_nettype wire

// >>> sic_init_power_cfg.sv
// register block: init sequence, power-down control, channel geometry
// assumes: one 40 MHz clock, axi4-lite master, refresh engine on same clock
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sic_defs.svh"
module sic_init_power_cfg #(
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// auto-refresh engine status, same clock
	input  wire logic              refresh_busy,
	// sdram side
	output logic                   init_precharge_cmd,
	output logic                   init_refresh_cmd,
	output logic [1:0]             power_down_active,
	output logic [1:0]             deep_power_down_active,
	// per-channel access request and beats
	input  wire logic [1:0]        acc_valid,
	output logic [1:0]             acc_ready,
	input  wire logic [1:0][31:0]  acc_addr,
	input  wire logic [1:0]        acc_word,
	output logic [1:0]             beat_valid,
	output logic [1:0][31:0]       beat_addr,
	output logic [1:0]             beat_last,
	output logic                   irq
);
	import sic_pkg::*;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// ============================================================
	// declarations
	logic [ADDR_W-1:0]  waddr_q;
	logic               aw_held_q;
	logic [31:0]        wdata_q;
	logic [3:0]         wstrb_q;
	logic               w_held_q;
	logic               wr_en;
	logic               wr_hit;
	logic [31:0]        rd_word;
	logic               rd_hit;
	logic               common_pd_q;
	logic               common_dpd_q;
	sic_width_type      bus_width_q [2];
	sic_size_type       chan_size_q [2];
	logic [10:0]        init_timing_q;
	sic_init_state_type init_state_q;
	logic               init_in_progress_q;
	logic [4:0]         cnt_q;
	logic [3:0]         refs_left_q;
	logic [3:0]         refs_seen_q;
	logic               init_done;
	logic               launch;
	logic [2:0]         irq_status_q;
	logic [2:0]         irq_enable_q;
	logic [2:0]         irq_event;
	logic [2:0]         irq_clear;
	logic               pd_enter;
	logic               dpd_enter;
	logic               access_ok;
	logic [2:0]         init_precharge_count;
	logic [3:0]         init_refresh_count;
	logic [3:0]         init_refresh_interval;

	assign init_precharge_count = init_timing_q[`SIC_PRECH_LSB +: 3];
	assign init_refresh_count = init_timing_q[`SIC_RCNT_LSB +: 4];
	assign init_refresh_interval = init_timing_q[`SIC_RINT_LSB +: 4];

	// ============================================================
	// axi write channels: address and data taken in either order
	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready = !w_held_q;
	assign wr_en = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			aw_held_q <= 1'b0;
			waddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			waddr_q <= s_axi_awaddr;
		end else if (wr_en) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			w_held_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_en) begin
			w_held_q <= 1'b0;
		end
	end

	// write address decode
	always_comb begin
		unique case (waddr_q)
			`SIC_OFF_INIT_CTRL, `SIC_OFF_PD_CTRL, `SIC_OFF_DPD_CTRL,
			`SIC_OFF_GEOM0, `SIC_OFF_GEOM1, `SIC_OFF_INIT_TIMING,
			`SIC_OFF_IRQ_ENABLE, `SIC_OFF_IRQ_CLEAR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// write response, slave error on unmapped address or the read-only status register
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SIC_RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `SIC_RESP_OKAY : `SIC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ============================================================
	// control registers; launch is a strobe, never stored
	assign launch = wr_en && waddr_q == `SIC_OFF_INIT_CTRL && wstrb_q[0]
		&& wdata_q[`SIC_LAUNCH_BIT];

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			common_pd_q <= 1'b0;
			common_dpd_q <= 1'b0;
			init_timing_q <= `SIC_TIMING_RESET;
			irq_enable_q <= 3'h0;
		end else if (wr_en) begin
			if (waddr_q == `SIC_OFF_PD_CTRL && wstrb_q[0])
				common_pd_q <= wdata_q[`SIC_PD_BIT];
			if (waddr_q == `SIC_OFF_DPD_CTRL && wstrb_q[0])
				common_dpd_q <= wdata_q[`SIC_PD_BIT];
			if (waddr_q == `SIC_OFF_INIT_TIMING) begin
				if (wstrb_q[0])
					init_timing_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1])
					init_timing_q[10:8] <= wdata_q[10:8];
			end
			if (waddr_q == `SIC_OFF_IRQ_ENABLE && wstrb_q[0])
				irq_enable_q <= wdata_q[2:0];
		end
	end

	// channel geometry, one register per channel
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int i = 0; i < 2; i++) begin
				{bus_width_q[i], chan_size_q[i]} <= `SIC_GEOM_RESET;
			end
		end else if (wr_en) begin
			for (int i = 0; i < 2; i++) begin
				if (waddr_q == (i == 0 ? `SIC_OFF_GEOM0 : `SIC_OFF_GEOM1)) begin
					if (wstrb_q[1])
						bus_width_q[i] <= wdata_q[`SIC_WIDTH_LSB +: 2];
					if (wstrb_q[0])
						chan_size_q[i] <= wdata_q[`SIC_SIZE_LSB +: 3];
				end
			end
		end
	end

	// ============================================================
	// common init sequence: precharge wait, then auto-refresh train
	assign init_done = init_state_q == SIC_REFR && cnt_q == 5'h0
		&& refs_left_q <= 4'h1;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			init_state_q <= SIC_IDLE;
			cnt_q <= 5'h0;
			refs_left_q <= 4'h0;
			init_precharge_cmd <= 1'b0;
			init_refresh_cmd <= 1'b0;
		end else begin
			init_precharge_cmd <= 1'b0;
			init_refresh_cmd <= 1'b0;
			unique case (init_state_q)
				SIC_IDLE: if (launch) begin
					init_state_q <= SIC_PRECH;
					init_precharge_cmd <= 1'b1;
					// code 0 is 3 cycles, code 7 is 10
					cnt_q <= {2'h0, init_precharge_count} + 5'(`SIC_PRECH_BASE)
						- 5'h1;
					// prohibited count 0 runs as a single refresh
					refs_left_q <= (init_refresh_count == 4'h0) ? 4'h1
						: init_refresh_count;
				end
				SIC_PRECH: if (cnt_q == 5'h0) begin
					init_state_q <= SIC_REFR;
					init_refresh_cmd <= 1'b1;
					cnt_q <= {1'b0, init_refresh_interval} + `SIC_RINT_BASE
						- 5'h1;
				end else begin
					cnt_q <= cnt_q - 5'h1;
				end
				SIC_REFR: if (cnt_q != 5'h0) begin
					cnt_q <= cnt_q - 5'h1;
				end else if (refs_left_q <= 4'h1) begin
					init_state_q <= SIC_IDLE;
					refs_left_q <= 4'h0;
				end else begin
					refs_left_q <= refs_left_q - 4'h1;
					init_refresh_cmd <= 1'b1;
					cnt_q <= {1'b0, init_refresh_interval} + `SIC_RINT_BASE
						- 5'h1;
				end
				default: init_state_q <= SIC_IDLE;
			endcase
		end
	end

	// in-progress flag, common to both channels
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			init_in_progress_q <= 1'b0;
		else if (launch && init_state_q == SIC_IDLE)
			init_in_progress_q <= 1'b1;
		else if (init_done)
			init_in_progress_q <= 1'b0;
	end

	// refresh commands seen in the current sequence, for checking
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			refs_seen_q <= 4'h0;
		else if (launch && init_state_q == SIC_IDLE)
			refs_seen_q <= 4'h0;
		else if (init_refresh_cmd)
			refs_seen_q <= refs_seen_q + 4'h1;
	end

	// ============================================================
	// power-down and deep-power-down, entry held off by refresh
	assign pd_enter = common_pd_q && !power_down_active[0] && !refresh_busy;
	assign dpd_enter = common_dpd_q && !deep_power_down_active[0]
		&& !refresh_busy;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			power_down_active <= 2'h0;
			deep_power_down_active <= 2'h0;
		end else begin
			if (!common_pd_q)
				power_down_active <= 2'h0;
			else if (pd_enter)
				power_down_active <= 2'h3;
			if (!common_dpd_q)
				deep_power_down_active <= 2'h0;
			else if (dpd_enter)
				deep_power_down_active <= 2'h3;
		end
	end

	// ============================================================
	// interrupt status: set wins over a clear in the same cycle
	assign irq_event = {dpd_enter, pd_enter, init_done};
	assign irq_clear = (wr_en && waddr_q == `SIC_OFF_IRQ_CLEAR && wstrb_q[0])
		? wdata_q[2:0] : 3'h0;

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			irq_status_q <= 3'h0;
		else
			irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
	end

	assign irq = |(irq_status_q & irq_enable_q);

	// ============================================================
	// register read mux; reserved bits stay zero
	always_comb begin
		rd_word = 32'h0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`SIC_OFF_INIT_CTRL: rd_word[`SIC_BUSY_BIT] = init_in_progress_q;
			`SIC_OFF_PD_CTRL: rd_word[`SIC_PD_BIT] = common_pd_q;
			`SIC_OFF_DPD_CTRL: rd_word[`SIC_PD_BIT] = common_dpd_q;
			`SIC_OFF_GEOM0: rd_word[9:0] = {bus_width_q[0], 5'h00,
				chan_size_q[0]};
			`SIC_OFF_GEOM1: rd_word[9:0] = {bus_width_q[1], 5'h00,
				chan_size_q[1]};
			`SIC_OFF_INIT_TIMING: rd_word[10:0] = init_timing_q;
			`SIC_OFF_IRQ_STATUS: rd_word[2:0] = irq_status_q;
			`SIC_OFF_IRQ_ENABLE: rd_word[2:0] = irq_enable_q;
			default: rd_hit = 1'b0; // clear register reads zero too
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `SIC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (rd_hit || s_axi_araddr == `SIC_OFF_IRQ_CLEAR)
				? `SIC_RESP_OKAY : `SIC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ============================================================
	// channel splitters; accesses held off during init and power-down
	assign access_ok = !init_in_progress_q && !common_pd_q && !common_dpd_q
		&& power_down_active == 2'h0 && deep_power_down_active == 2'h0;

	for (genvar g = 0; g < 2; g++) begin : g_chan
		sic_chan_if chif ();
		assign chif.cfg_width = bus_width_q[g];
		assign chif.cfg_size = chan_size_q[g];
		assign chif.req_valid = acc_valid[g] && access_ok;
		assign chif.req_addr = acc_addr[g];
		assign chif.req_word = acc_word[g];
		assign acc_ready[g] = chif.req_ready && access_ok;
		assign beat_valid[g] = chif.beat_valid;
		assign beat_addr[g] = chif.beat_addr;
		assign beat_last[g] = chif.beat_last;
		sic_chan_split u_split (
			.sys_clk (sys_clk),
			.rstn    (rstn),
			.ch      (chif.chan)
		);
	end

	// ============================================================
	// checks
	launch_sets_a: assert property (launch && init_state_q == SIC_IDLE
		|=> init_in_progress_q && init_precharge_cmd)
		else $error("launch did not set busy flag");
	flag_clears_a: assert property (init_done |=> !init_in_progress_q
		&& init_state_q == SIC_IDLE)
		else $error("busy flag did not clear at end");
	launch_read_a: assert property (s_axi_rvalid
		&& $past(s_axi_araddr) == `SIC_OFF_INIT_CTRL && $rose(s_axi_rvalid)
		|-> s_axi_rdata[`SIC_LAUNCH_BIT] == 1'b0)
		else $error("launch bit read back as one");
	reserved_zero_a: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:17] == 15'h0)
		else $error("reserved bits not zero");
	busy_tracks_a: assert property (init_state_q != SIC_IDLE
		|-> init_in_progress_q)
		else $error("busy flag low during sequence");
	pd_defer_a: assert property ($rose(power_down_active[0])
		|-> $past(!refresh_busy && common_pd_q))
		else $error("power-down entered during refresh");
	pd_exit_a: assert property (!common_pd_q |=> power_down_active == 2'h0)
		else $error("power-down not left");
	dpd_defer_a: assert property ($rose(deep_power_down_active[0])
		|-> $past(!refresh_busy) && deep_power_down_active == 2'h3)
		else $error("deep-power-down entry wrong");
	dpd_exit_a: assert property (!common_dpd_q
		|=> deep_power_down_active == 2'h0)
		else $error("deep-power-down not left");
	prech_len_a: assert property ($rose(init_precharge_cmd)
		##0 (init_precharge_count == 3'h0 && !launch) |->
		##3 init_refresh_cmd)
		else $error("precharge wait not 3 cycles");
	refresh_count_a: assert property (init_done && init_refresh_count != 4'h0
		&& $stable(init_timing_q) |-> refs_seen_q == init_refresh_count)
		else $error("wrong number of init refreshes");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");

	init_cov: cover property (init_done);
	pd_wait_cov: cover property (common_pd_q && refresh_busy
		##1 !refresh_busy ##1 power_down_active[0]);
	dpd_cov: cover property ($rose(deep_power_down_active[0]));
	irq_cov: cover property ($rose(irq));
endmodule // sic_init_power_cfg
`default_nettype wire

// >>> sic_sdram_model.sv
// sdram side stand-in: refresh engine and init command monitor
// assumes: same clock as the block, pulses last one cycle
`timescale 1ns/1ps
`default_nettype none
module sic_sdram_model (
	input  wire logic sys_clk,
	input  wire logic refr_go,
	input  wire logic init_precharge_cmd,
	input  wire logic init_refresh_cmd,
	output wire logic refresh_busy,
	output var  int   refr_cnt,
	output var  int   prech_gap
);
	int left = 0;
	int gap = 0;
	// ============================================================
	// refresh runs a fixed span after each go, slow on purpose
	// non-blocking so the block samples busy cleanly at the edge
	always @(posedge sys_clk) begin
		if (refr_go)
			left <= 20;
		else if (left > 0)
			left <= left - 1;
	end
	assign refresh_busy = (left > 0);
	// count init refreshes and the precharge to refresh gap
	always @(posedge sys_clk) begin
		gap = gap + 1;
		if (init_precharge_cmd) begin
			gap = 0;
			refr_cnt = 0;
		end
		if (init_refresh_cmd) begin
			if (refr_cnt == 0)
				prech_gap = gap;
			refr_cnt = refr_cnt + 1;
		end
	end
endmodule // sic_sdram_model
`default_nettype wire

// >>> sic_init_power_cfg_tb.sv
// self-checking bench for the sdram init and power configuration block
// assumes: package, interface and design modules compiled before it
`timescale 1ns/1ps
`default_nettype none
module sic_init_power_cfg_tb;
	logic sys_clk = 1'h0, rstn = 1'h0, refr_go = 1'h0, irq, pc, rc, rbusy;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic rready = 1'h0, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd, seed = 32'hF54E;
	logic [1:0] bresp, rresp, rs, pda, dpda, ardy, bv, bl;
	logic [1:0] av = 2'h0, aw = 2'h0;
	logic [1:0][31:0] aa = '0, ba;
	int error_cnt = 0, n_checks = 0, rcnt, pgap;
	// ============================================================
	// clock, design and far side
	always #12.5 sys_clk = ~sys_clk;
	sic_init_power_cfg sic_init_power_cfg_i (.sys_clk(sys_clk), .rstn(rstn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .refresh_busy(rbusy),
		.init_precharge_cmd(pc), .init_refresh_cmd(rc),
		.power_down_active(pda), .deep_power_down_active(dpda),
		.acc_valid(av), .acc_ready(ardy), .acc_addr(aa), .acc_word(aw),
		.beat_valid(bv), .beat_addr(ba), .beat_last(bl), .irq(irq));
	sic_sdram_model sic_sdram_model_i (.sys_clk(sys_clk), .refr_go(refr_go),
		.init_precharge_cmd(pc), .init_refresh_cmd(rc),
		.refresh_busy(rbusy), .refr_cnt(rcnt), .prech_gap(pgap));
	// ============================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		rs = bresp;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge sys_clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		{arvalid, rready} <= 2'h0;
		rd = rdata;
		rs = rresp;
	endtask
	// one word access, beats compared with the split model
	task automatic acc(input int c, input int w, input logic [2:0] s);
		logic [31:0] a;
		int n;
		seed = lfsr(seed);
		a = seed & ((32'h1 << (20 + s)) - 32'h1);
		if (w != 2) a = a & ~32'h3;
		n = (w == 0) ? 4 : (w == 1) ? 2 : 1;
		@(posedge sys_clk);
		av[c] <= 1'h1;
		aa[c] <= seed;
		aw[c] <= 1'h1;
		do @(posedge sys_clk); while (ardy[c] !== 1'h1);
		av[c] <= 1'h0;
		for (int k = 0; k < n; k++) begin
			@(posedge sys_clk);
			chk({bv[c], bl[c]}, {1'h1, k == n - 1});
			chk(ba[c], a + 32'(k * ((w == 0) ? 1 : 2)));
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d error_cnt=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ============================================================
	// main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'h1;
		rd_reg(8'h00);
		chk(rd, 32'h0);
		wr(8'h04, 32'hFFFFFFFE);
		rd_reg(8'h04);
		chk(rd, 32'h0);
		wr(8'h40, 32'h1);
		chk(rs, 32'h2);
		wr(8'h1C, 32'h7);
		wr(8'h14, 32'h230);
		wr(8'h00, 32'h1);
		rd_reg(8'h00);
		chk(rd, 32'h10000);
		chk(irq, 32'h0);
		for (int i = 0; i < 60 && rd !== 32'h0; i++) rd_reg(8'h00);
		chk(rd, 32'h0);
		chk(rcnt, 3);
		chk(pgap, 5);
		// shortest sequence: precharge code 0, one refresh
		wr(8'h14, 32'h010);
		wr(8'h00, 32'h1);
		rd_reg(8'h00);
		for (int i = 0; i < 60 && rd !== 32'h0; i++) rd_reg(8'h00);
		chk(rd, 32'h0);
		chk(rcnt, 1);
		chk(pgap, 3);
		chk(irq, 32'h1);
		wr(8'h1C, 32'h0);
		chk(irq, 32'h0);
		wr(8'h1C, 32'h7);
		wr(8'h20, 32'h7);
		chk(irq, 32'h0);
		for (int p = 0; p < 2; p++) begin
			@(posedge sys_clk);
			refr_go <= 1'h1;
			@(posedge sys_clk);
			refr_go <= 1'h0;
			wr(8'(4 + 4 * p), 32'h1);
			chk({ardy, pda, dpda}, 32'h0);
			while (rbusy) @(posedge sys_clk);
			repeat (2) @(posedge sys_clk);
			chk({pda, dpda}, p ? 32'h3 : 32'hC);
			chk(irq, 32'h1);
			wr(8'(4 + 4 * p), 32'h0);
			wr(8'h20, 32'h7);
			chk({pda, dpda}, 32'h0);
		end
		for (int c = 0; c < 2; c++)
			for (int w = 0; w < 3; w++) begin
				seed = lfsr(seed);
				wr(8'(12 + 4 * c), 32'hFFFFFC00 | (w << 8) | seed[2:0]);
				rd_reg(8'(12 + 4 * c));
				chk(rd, (w << 8) | seed[2:0]);
				acc(c, w, seed[2:0]);
			end
		print_verdict;
	end
	// hang guard, far beyond the expected run
	initial begin
		#2000000;
		error_cnt++;
		print_verdict;
	end
endmodule // sic_init_power_cfg_tb
`default_nettype wire
